// file: hdl/pcc_top.sv
// PWM cycle configuration block: cycle length, reload bank and overflow flag.
// -----------------------------------------------------------------
// Notes on behaviour
// - Select bit 0 maps the compare addresses to compare registers, 1 to reload registers.
// - Reload values feed the compare registers only in 9, 10 and 11-bit PWM.
// - In every other mode the reload registers have no effect.
// - The interrupt request is raised while the flag is set and its enable is 1.
// - The flag sets when the counter overflows the bit chosen by the cycle length.
// - Hardware or a software 1 sets the flag; only a software 0 clears it.
// - Bits 4 to 2 of the configuration register read zero and ignore writes.
// - Cycle length 00/01/10/11 selects 8/9/10/11 bits.
// - One cycle length applies to every narrow PWM channel.
// - Channels in 16-bit PWM ignore the cycle length.
// - The wide PWM bit picks 16-bit PWM when 1, narrow PWM when 0.
// -----------------------------------------------------------------
`timescale 1ns/1ps
module pcc_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic cnt_tick_i,
   input wire logic [pcc_pkg::PCC_NCH-1:0] pwm_en_i,
   input wire logic [pcc_pkg::PCC_NCH-1:0] wide_pwm_select_i,
   output logic [7:0] sfr_rdata_o,
   output logic irq_o,
   output logic [15:0] main_array_counter_o,
   output logic [pcc_pkg::PCC_NCH-1:0] pwm_o
);
   import pcc_pkg::*;

   // ---------------------------------------------------------------
   // Reset synchroniser
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   // All state leaves reset on one edge, two clocks after the pin is released.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic reload_bank_select;
      logic cycle_overflow_irq_enable;
      logic cycle_overflow_flag;
      logic [1:0] cycle_length_select;
      logic [15:0] cnt;
      logic [7:0] rdata;
      logic irq;
      logic [PCC_NCH-1:0] pwm;
   } pcc_state_s;
   // Every register of this module except the reset synchroniser lives in this one struct.

   pcc_state_s st;
   pcc_state_s next_st;

   logic [PCC_NCH*16-1:0] cmp;
   logic [PCC_NCH*16-1:0] rld;
   logic [PCC_NCH-1:0] wr_lo;
   logic [PCC_NCH-1:0] wr_hi;
   logic [PCC_NCH-1:0] reload;
   logic [PCC_NCH-1:0] rd_lo;
   logic [PCC_NCH-1:0] rd_hi;
   logic cyc_ovf;
   logic [15:0] cnt_inc;

   // ---------------------------------------------------------------
   // Address helpers
   // ---------------------------------------------------------------
   function automatic logic cfg_hit(input logic [7:0] addr);
      cfg_hit = addr == PCC_ADDR_CFG;
   endfunction : cfg_hit

   function automatic logic [7:0] lo_addr(input int ch);
      case (ch)
         0: lo_addr = PCC_ADDR_CMP_LO0;
         1: lo_addr = PCC_ADDR_CMP_LO1;
         default: lo_addr = PCC_ADDR_CMP_LO2;
      endcase
   endfunction : lo_addr

   function automatic logic [7:0] hi_addr(input int ch);
      case (ch)
         0: hi_addr = PCC_ADDR_CMP_HI0;
         1: hi_addr = PCC_ADDR_CMP_HI1;
         default: hi_addr = PCC_ADDR_CMP_HI2;
      endcase
   endfunction : hi_addr

   // Mask of the counter bits that belong to the narrow PWM cycle.
   function automatic logic [10:0] len_mask(input logic [1:0] sel);
      unique case (pcc_len_e'(sel))
         PCC_LEN8: len_mask = 11'h0ff;
         PCC_LEN9: len_mask = 11'h1ff;
         PCC_LEN10: len_mask = 11'h3ff;
         PCC_LEN11: len_mask = 11'h7ff;
      endcase
   endfunction : len_mask

   // ---------------------------------------------------------------
   // Address decode and overflow detection
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PCC_NCH; g++) begin : g_dec
         assign wr_lo[g] = sfr_wr_i && (sfr_addr_i == lo_addr(g));
         assign wr_hi[g] = sfr_wr_i && (sfr_addr_i == hi_addr(g));
         assign rd_lo[g] = sfr_addr_i == lo_addr(g);
         assign rd_hi[g] = sfr_addr_i == hi_addr(g);
         // Narrow channels reload only in 9 to 11-bit lengths; wide ones never.
         assign reload[g] = cyc_ovf && pwm_en_i[g] && !wide_pwm_select_i[g]
                            && (st.cycle_length_select != PCC_LEN8);
      end
   endgenerate

   // The main counter wraps at 16 bits; wide channels see its full range.
   assign cnt_inc = st.cnt + 16'h0001;
   // Overflow out of the selected bit: all cycle bits set on a counting tick.
   assign cyc_ovf = cnt_tick_i
      && ((st.cnt[10:0] & len_mask(st.cycle_length_select))
          == len_mask(st.cycle_length_select));

   // ---------------------------------------------------------------
   // Channel storage
   // ---------------------------------------------------------------
   // A compare write in a reload cycle is lost, so duty updates go through the reload bank.
   pcc_chan_bank u_bank (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .wr_lo_i(wr_lo),
      .wr_hi_i(wr_hi),
      .rsel_i(st.reload_bank_select),
      .wdata_i(sfr_wdata_i),
      .reload_i(reload),
      .cmp_o(cmp),
      .rld_o(rld)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [10:0] m;
      logic [15:0] bank;
      m = len_mask(st.cycle_length_select);
      bank = 16'h0000;
      next_st = st;
      if (cnt_tick_i) begin
         next_st.cnt = cnt_inc;
      end
      if (sfr_wr_i && cfg_hit(sfr_addr_i)) begin
         next_st.reload_bank_select = sfr_wdata_i[PCC_BIT_RSEL];
         next_st.cycle_overflow_irq_enable = sfr_wdata_i[PCC_BIT_IEN];
         next_st.cycle_overflow_flag = sfr_wdata_i[PCC_BIT_FLAG];
         next_st.cycle_length_select = sfr_wdata_i[PCC_BIT_CLS_HI:PCC_BIT_CLS_LO];
      end
      // A hardware overflow wins over a software clear in the same cycle.
      if (cyc_ovf) begin
         next_st.cycle_overflow_flag = 1'b1;
      end
      next_st.irq = next_st.cycle_overflow_flag
                    && next_st.cycle_overflow_irq_enable;
      // Read data stand for one cycle after the strobe and are zero otherwise.
      next_st.rdata = 8'h00;
      if (sfr_rd_i) begin
         if (cfg_hit(sfr_addr_i)) begin
            next_st.rdata = {st.reload_bank_select, st.cycle_overflow_irq_enable,
                             st.cycle_overflow_flag, 3'b000,
                             st.cycle_length_select};
         end
         // Channel reads are steered by the bank select, like writes.
         for (int i = 0; i < PCC_NCH; i++) begin
            bank = st.reload_bank_select ? rld[i*16 +: 16] : cmp[i*16 +: 16];
            if (rd_lo[i]) begin
               next_st.rdata = bank[7:0];
            end
            if (rd_hi[i]) begin
               next_st.rdata = bank[15:8];
            end
         end
      end
      // A disabled channel holds its output low.
      for (int i = 0; i < PCC_NCH; i++) begin
         if (!pwm_en_i[i]) begin
            next_st.pwm[i] = 1'b0;
         end else if (wide_pwm_select_i[i]) begin
            next_st.pwm[i] = st.cnt < cmp[i*16 +: 16];
         end else begin
            next_st.pwm[i] = (st.cnt[10:0] & m) < (cmp[i*16 +: 11] & m);
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign sfr_rdata_o = st.rdata;
   assign irq_o = st.irq;
   assign main_array_counter_o = st.cnt;
   assign pwm_o = st.pwm;
endmodule : pcc_top

// file: hdl/pcc_pkg.sv
// Package of constants for the PWM cycle configuration block.
package pcc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PCC_ADDR_CFG = 8'hdf;
   localparam logic [7:0] PCC_ADDR_CMP_LO0 = 8'he9;
   localparam logic [7:0] PCC_ADDR_CMP_HI0 = 8'hfa;
   localparam logic [7:0] PCC_ADDR_CMP_LO1 = 8'heb;
   localparam logic [7:0] PCC_ADDR_CMP_HI1 = 8'hfb;
   localparam logic [7:0] PCC_ADDR_CMP_LO2 = 8'hec;
   localparam logic [7:0] PCC_ADDR_CMP_HI2 = 8'hfc;
   localparam int PCC_NCH = 3;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int PCC_BIT_RSEL = 7;
   localparam int PCC_BIT_IEN = 6;
   localparam int PCC_BIT_FLAG = 5;
   localparam int PCC_BIT_CLS_HI = 1;
   localparam int PCC_BIT_CLS_LO = 0;
   localparam logic [7:0] PCC_CFG_RESET = 8'h00;
   localparam logic [15:0] PCC_CMP_RESET = 16'h0000;
   localparam logic [15:0] PCC_RLD_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // Cycle length encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PCC_LEN8 = 2'b00,
      PCC_LEN9 = 2'b01,
      PCC_LEN10 = 2'b10,
      PCC_LEN11 = 2'b11
   } pcc_len_e;
endpackage : pcc_pkg

// file: hdl/pcc_chan_bank.sv
// Compare and auto-reload storage for all channels.
`timescale 1ns/1ps
module pcc_chan_bank (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [pcc_pkg::PCC_NCH-1:0] wr_lo_i,
   input wire logic [pcc_pkg::PCC_NCH-1:0] wr_hi_i,
   input wire logic rsel_i,
   input wire logic [7:0] wdata_i,
   input wire logic [pcc_pkg::PCC_NCH-1:0] reload_i,
   output logic [pcc_pkg::PCC_NCH*16-1:0] cmp_o,
   output logic [pcc_pkg::PCC_NCH*16-1:0] rld_o
);
   import pcc_pkg::*;
   // ---------------------------------------------------------------
   // Per-channel storage
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PCC_NCH; g++) begin : g_ch
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cmp_o[g*16 +: 16] <= PCC_CMP_RESET;
               rld_o[g*16 +: 16] <= PCC_RLD_RESET;
            end else begin
               if (wr_lo_i[g] && rsel_i) begin
                  rld_o[g*16 +: 8] <= wdata_i;
               end
               if (wr_hi_i[g] && rsel_i) begin
                  rld_o[g*16+8 +: 8] <= wdata_i;
               end
               if (reload_i[g]) begin
                  cmp_o[g*16 +: 16] <= rld_o[g*16 +: 16];
               end else begin
                  if (wr_lo_i[g] && !rsel_i) begin
                     cmp_o[g*16 +: 8] <= wdata_i;
                  end
                  if (wr_hi_i[g] && !rsel_i) begin
                     cmp_o[g*16+8 +: 8] <= wdata_i;
                  end
               end
            end
         end
      end
   endgenerate
endmodule : pcc_chan_bank

// file: tb/pcc_top_monitor.sv
// Port checker of the PWM cycle configuration block.
`timescale 1ns/1ps
module pcc_top_monitor
   import pcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic cnt_tick_i,
   input wire logic [15:0] main_array_counter_o,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire cw = sfr_wr_i && sfr_addr_i == PCC_ADDR_CFG;
   wire cr = sfr_rd_i && sfr_addr_i == PCC_ADDR_CFG && !sfr_wr_i;
   a_unused_zero: assert property (cr |=> sfr_rdata_o[4:2] == 3'h0)
      else $error("unused bits read nonzero");
   a_unmapped_zero: assert property (sfr_rd_i && sfr_addr_i == 8'h00 |=> sfr_rdata_o == 8'h00)
      else $error("unmapped read nonzero");
   a_cfg_readback: assert property (cw ##1 cr |=> sfr_rdata_o[7:6] == $past(sfr_wdata_i[7:6], 2)
      && sfr_rdata_o[1:0] == $past(sfr_wdata_i[1:0], 2)) else $error("cfg readback wrong");
   a_flag_sets: assert property (cnt_tick_i && !sfr_wr_i && main_array_counter_o[10:0] == 11'h7ff
      ##1 cr |=> sfr_rdata_o[5]) else $error("overflow flag not set");
   a_irq_match: assert property (cr && !cnt_tick_i && !$past(sfr_wr_i) && !$past(cnt_tick_i)
      |=> irq_o == (sfr_rdata_o[6] && sfr_rdata_o[5])) else $error("irq differs from flag");
   a_irq_masked: assert property (cw && !sfr_wdata_i[6] ##1 !cw |=> !irq_o)
      else $error("irq while disabled");
   a_sw_set: assert property (cw && sfr_wdata_i[6] && sfr_wdata_i[5] ##1 !cw |=> irq_o)
      else $error("software set lost");
   a_irq_hold: assert property (irq_o && !cw && !$past(cw) |=> irq_o)
      else $error("flag cleared by hardware");
endmodule : pcc_top_monitor
bind pcc_top pcc_top_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .cnt_tick_i(cnt_tick_i),
   .main_array_counter_o(main_array_counter_o), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o));

// file: tb/test_pcc_top.sv
// Self-checking bench of the PWM cycle configuration block.
`timescale 1ns/1ps
module test_pcc_top;
   import pcc_pkg::*;
   logic clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, cnt_tick_i, irq_o;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, d;
   logic [PCC_NCH-1:0] pwm_en_i, wide_pwm_select_i, pwm_o;
   logic [15:0] main_array_counter_o;
   int miscompares = 0;
   int checks = 0;
   int n;
   pcc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .cnt_tick_i(cnt_tick_i), .pwm_en_i(pwm_en_i), .wide_pwm_select_i(wide_pwm_select_i),
      .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o), .main_array_counter_o(main_array_counter_o),
      .pwm_o(pwm_o));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Every drive starts and ends at a falling edge, so strobes may stay high back to back.
   task automatic drv(input logic w, input logic r, input logic t, input logic [7:0] a,
      input logic [7:0] v);
      {sfr_wr_i, sfr_rd_i, cnt_tick_i} = {w, r, t};
      sfr_addr_i = a;
      sfr_wdata_i = v;
      @(negedge clk_i);
   endtask : drv
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      drv(1'b1, 1'b0, 1'b0, a, v);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      drv(1'b0, 1'b1, 1'b0, a, 8'h00);
      d = sfr_rdata_o;
   endtask : rd
   task automatic idle(input int c);
      repeat (c) drv(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
   endtask : idle
   task automatic tick(input int c);
      repeat (c) drv(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
   endtask : tick
   task automatic rst;
      rst_n_i = 1'b0;
      idle(3);
      rst_n_i = 1'b1;
      idle(3);
   endtask : rst
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic t_cfg;
      rd(PCC_ADDR_CFG);
      chk("cfg reset", d, PCC_CFG_RESET);
      rd(8'h00);
      chk("unmapped", d, 8'h00);
      wr(PCC_ADDR_CFG, 8'hff);
      rd(PCC_ADDR_CFG);
      chk("cfg all ones", d, 8'he3);
      chk("irq set", irq_o, 1'b1);
      wr(PCC_ADDR_CFG, 8'h20);
      idle(2);
      chk("irq masked", irq_o, 1'b0);
      rd(PCC_ADDR_CFG);
      chk("flag held", d, 8'h20);
      wr(PCC_ADDR_CFG, 8'h00);
      rd(PCC_ADDR_CFG);
      chk("flag clear", d, 8'h00);
      for (int l = 0; l < 4; l++) begin
         wr(PCC_ADDR_CFG, 8'(l));
         rd(PCC_ADDR_CFG);
         chk("length", d, 16'(l));
      end
      $display("test cfg done");
   endtask : t_cfg
   task automatic t_ovf;
      for (int l = 0; l < 4; l++) begin
         rst;
         wr(PCC_ADDR_CFG, 8'h40 | 8'(l));
         n = 0;
         d = 8'h00;
         while (d[5] !== 1'b1 && n < 4096) begin
            tick(1);
            rd(PCC_ADDR_CFG);
            n++;
         end
         if (d[5] !== 1'b1) begin
            miscompares++;
            complete_run;
         end
         chk("ticks", 16'(n), 16'(1 << (8 + l)));
         chk("counter", main_array_counter_o, 16'(1 << (8 + l)));
         chk("irq", irq_o, 1'b1);
      end
      $display("test overflow done");
   endtask : t_ovf
   task automatic t_rld;
      rst;
      pwm_en_i = 3'b111;
      wide_pwm_select_i = 3'b010;
      wr(PCC_ADDR_CFG, 8'h80);
      wr(PCC_ADDR_CMP_LO0, 8'hff);
      wr(PCC_ADDR_CMP_HI0, 8'h01);
      rd(PCC_ADDR_CMP_LO0);
      chk("reload bank", d, 8'hff);
      wr(PCC_ADDR_CFG, 8'h00);
      rd(PCC_ADDR_CMP_LO0);
      chk("compare bank", d, 8'h00);
      tick(300);
      idle(2);
      chk("pwm 8 bit", pwm_o[0], 1'b0);
      wr(PCC_ADDR_CFG, 8'h01);
      tick(220);
      idle(2);
      rd(PCC_ADDR_CMP_LO0);
      chk("reloaded", d, 8'hff);
      chk("pwm 9 bit", pwm_o[0], 1'b1);
      // Counter now stands at 0x208; both channels compare against 0x100.
      wr(PCC_ADDR_CMP_HI1, 8'h01);
      wr(PCC_ADDR_CMP_HI2, 8'h01);
      idle(2);
      chk("pwm wide", pwm_o[1], 1'b0);
      chk("pwm narrow", pwm_o[2], 1'b1);
      $display("test reload done");
   endtask : t_rld
   initial begin
      pwm_en_i = '0;
      wide_pwm_select_i = '0;
      rst;
      t_cfg;
      t_ovf;
      t_rld;
      complete_run;
   end
endmodule : test_pcc_top
